/* verilog/air_defines.svh */
`ifndef AIR_DEFINES_SVH
`define AIR_DEFINES_SVH
// parameter identifiers
`define AIR_PID_MATRIX_BASE 32'h07000500
`define AIR_PID_MATRIX_LAST 32'h07000505
`define AIR_PID_FORCE_SEL   32'h07000400
`define AIR_PID_SRC_SEL     32'h06000500
`define AIR_PID_TGT_OFS     32'h06000501
// command limits and levels
`define AIR_MAX_ARGS        4'hc
`define AIR_LEVEL_ADV       2'h1
// normalisation: full scale input code maps to +/-100
`define AIR_NORM_FULL       16'h0064
// nonvolatile defaults
`define AIR_SEL_RESET       3'h0
`endif

/* verilog/air_pkg.sv */
package air_pkg;
  typedef enum logic [2:0] {
    AIR_OP_NONE  = 3'h0,
    AIR_OP_SET   = 3'h1,
    AIR_OP_NVW   = 3'h2,
    AIR_OP_SAVE  = 3'h3,
    AIR_OP_OFS   = 3'h4,
    AIR_OP_STOP  = 3'h5,
    AIR_OP_LEVEL = 3'h6
  } air_op_t;
  typedef enum logic [1:0] {
    AIR_ST_LOAD = 2'h0,
    AIR_ST_RUN  = 2'h1
  } air_state_t;
endpackage

/* verilog/air_cmd_if.sv */
// decoded parameter write, shared between top and the store
interface air_cmd_if #(parameter int AXES = 2, parameter int DW = 32);
  logic                    wr_vol;
  logic                    wr_nv;
  logic                    save;
  logic [$clog2(AXES)-1:0] axis;
  logic [31:0]             pid;
  logic signed [DW-1:0]    value;
  modport master (output wr_vol, output wr_nv, output save, output axis, output pid,
                  output value);
  modport slave  (input wr_vol, input wr_nv, input save, input axis, input pid,
                  input value);
endinterface

/* verilog/air_norm.sv */
`include "air_defines.svh"
// linear normalisation of one input code to +/-100 scale, then offset plus gain
module air_norm import air_pkg::*; #(
  parameter int DW = 32
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic signed [15:0]   raw,
  input  wire logic signed [DW-1:0] offset,
  input  wire logic signed [DW-1:0] gain,
  output logic signed [DW-1:0]      scaled
);
  initial if (DW < 24) $error("air_norm: DW too small");
  // code 0x7fff is +10 V; result keeps integer units of the normalised scale
  wire signed [31:0] norm_w =
    32'(($signed(32'(raw)) * $signed({16'h0, `AIR_NORM_FULL})) / 32'sh7fff);
  wire signed [DW-1:0] scaled_nxt = DW'(offset + gain * DW'(norm_w));
  always_ff @(posedge sys_clk) begin
    if (rst) scaled <= '0;
    else scaled <= scaled_nxt;
  end
endmodule

/* verilog/air_routing.sv */
`include "air_defines.svh"
module air_routing import air_pkg::*; #(
  parameter int AXES = 2,
  parameter int CHANS = 6,
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // command port
  input  wire logic                        cmd_valid,
  input  wire air_op_t                     cmd_op,
  input  wire logic [3:0]                  cmd_nargs,
  input  wire logic [$clog2(AXES)-1:0]     cmd_axis,
  input  wire logic [31:0]                 cmd_pid,
  input  wire logic signed [DW-1:0]        cmd_value,
  input  wire logic [1:0]                  cmd_level_req,
  // channels and motion inputs
  input  wire logic signed [CHANS*16-1:0]  chan_raw,
  input  wire logic signed [CHANS*DW-1:0]  chan_offset,
  input  wire logic signed [CHANS*DW-1:0]  chan_gain,
  input  wire logic [AXES-1:0]             servo_on,
  input  wire logic signed [AXES*DW-1:0]   motion_target,
  // results
  output logic                             cmd_ack,
  output logic                             cmd_err,
  output logic [1:0]                       level,
  output logic signed [AXES*DW-1:0]        pos_fb,
  output logic signed [AXES*DW-1:0]        force_fb,
  output logic signed [AXES*DW-1:0]        axis_target,
  output logic signed [AXES*DW-1:0]        axis_control,
  output logic [AXES-1:0]                  src_active,
  output logic signed [CHANS*DW-1:0]       chan_value,
  output logic signed [DW-1:0]             rd_vol,
  output logic signed [DW-1:0]             rd_nv
);
  localparam int AW = $clog2(AXES);
  initial if (AXES < 2 || CHANS < 1 || CHANS > 7 || DW < 24)
    $error("air_routing: unsupported parameters");

  air_cmd_if #(.AXES(AXES), .DW(DW)) cif ();

  // per channel scaling
  logic signed [DW-1:0] sval [CHANS];
  genvar gc;
  generate
    for (gc = 0; gc < CHANS; gc++) begin : g_ch
      air_norm #(.DW(DW)) u_norm (
        .sys_clk (sys_clk),
        .rst     (rst),
        .raw     (chan_raw[gc*16 +: 16]),
        .offset  (chan_offset[gc*DW +: DW]),
        .gain    (chan_gain[gc*DW +: DW]),
        .scaled  (sval[gc])
      );
    end
  endgenerate

  // command decode; level change needs level 1 password checked upstream
  wire is_set   = cmd_valid && cmd_op == AIR_OP_SET;
  wire is_nvw   = cmd_valid && cmd_op == AIR_OP_NVW;
  wire is_save  = cmd_valid && cmd_op == AIR_OP_SAVE;
  wire is_ofs   = cmd_valid && cmd_op == AIR_OP_OFS;
  wire is_stop  = cmd_valid && cmd_op == AIR_OP_STOP;
  wire is_lvl   = cmd_valid && cmd_op == AIR_OP_LEVEL;
  wire args_ok  = cmd_nargs <= `AIR_MAX_ARGS;
  wire priv_ok  = level == `AIR_LEVEL_ADV;
  wire need_lv  = is_set || is_nvw || is_save;
  wire accept   = cmd_valid && args_ok && (!need_lv || priv_ok);

  // route accepted writes to the store
  assign cif.wr_vol = accept && (is_set || is_ofs);
  assign cif.wr_nv  = accept && is_nvw;
  assign cif.save   = accept && is_save;
  assign cif.axis   = cmd_axis;
  assign cif.pid    = is_ofs ? `AIR_PID_TGT_OFS : cmd_pid;
  assign cif.value  = cmd_value;

  logic [2:0]           src_sel   [AXES];
  logic [2:0]           force_sel [AXES];
  logic signed [DW-1:0] tgt_ofs   [AXES];
  logic signed [DW-1:0] coef      [AXES][CHANS];
  logic                 load_done;

  air_store #(.AXES(AXES), .CHANS(CHANS), .DW(DW)) u_store (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .cmd       (cif.slave),
    .stop_req  (accept && is_stop),
    .stop_axis (cmd_axis),
    .src_sel   (src_sel),
    .force_sel (force_sel),
    .tgt_ofs   (tgt_ofs),
    .coef      (coef),
    .rd_vol    (rd_vol),
    .rd_nv     (rd_nv),
    .load_done (load_done)
  );

  // command answer and level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_ack <= 1'b0;
      cmd_err <= 1'b0;
      level   <= 2'h0;
    end else begin
      cmd_ack <= cmd_valid;
      cmd_err <= cmd_valid && !accept;
      if (is_lvl && args_ok) level <= cmd_level_req;
    end
  end

  // per axis routing
  genvar ga;
  generate
    for (ga = 0; ga < AXES; ga++) begin : g_ax
      logic signed [DW-1:0] fb_sum;
      // weighted sum of channels; coefficient 1 gives the channel itself
      always_comb begin
        fb_sum = '0;
        for (int c = 0; c < CHANS; c++)
          fb_sum = DW'(fb_sum + DW'(coef[ga][c] * sval[c]));
      end
      wire                  src_on  = load_done && src_sel[ga] != 3'h0 &&
                                      int'(src_sel[ga]) <= CHANS;
      wire [2:0]            src_idx = src_sel[ga] - 3'h1;
      wire [2:0]            frc_idx = force_sel[ga] - 3'h1;
      wire signed [DW-1:0]  src_val = DW'(sval[src_idx] + tgt_ofs[ga]);
      wire signed [DW-1:0]  frc_val = (force_sel[ga] != 3'h0 &&
                                      int'(force_sel[ga]) <= CHANS) ? sval[frc_idx] : '0;
      wire signed [DW-1:0]  cmd_val = src_on ? src_val : motion_target[ga*DW +: DW];
      // servo on drives target, off drives control
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pos_fb[ga*DW +: DW]       <= '0;
          force_fb[ga*DW +: DW]     <= '0;
          axis_target[ga*DW +: DW]  <= '0;
          axis_control[ga*DW +: DW] <= '0;
          src_active[ga]            <= 1'b0;
        end else begin
          pos_fb[ga*DW +: DW]       <= fb_sum;
          force_fb[ga*DW +: DW]     <= frc_val;
          src_active[ga]            <= src_on;
          if (servo_on[ga]) axis_target[ga*DW +: DW] <= cmd_val;
          else axis_control[ga*DW +: DW] <= cmd_val;
        end
      end

      // stop clears selector within two cycles
      a_stop_clears: assert property (@(posedge sys_clk) disable iff (rst)
        (accept && is_stop && cmd_axis == AW'(ga)) |-> ##2 !src_active[ga])
        else $error("selector not cleared by stop");
      a_zero_disconn: assert property (@(posedge sys_clk) disable iff (rst)
        (src_sel[ga] == 3'h0) |=> !src_active[ga])
        else $error("source active with zero selector");
      // target equals channel plus offset under servo
      a_src_offset: assert property (@(posedge sys_clk) disable iff (rst)
        (src_on && servo_on[ga]) |=> axis_target[ga*DW +: DW] == $past(src_val))
        else $error("target differs from source plus offset");
      a_servo_off: assert property (@(posedge sys_clk) disable iff (rst)
        !servo_on[ga] |=> $stable(axis_target[ga*DW +: DW]))
        else $error("target moved with servo off");
      a_force_sel: assert property (@(posedge sys_clk) disable iff (rst)
        (force_sel[ga] == 3'h0) |=> force_fb[ga*DW +: DW] == '0)
        else $error("force feedback without selector");
    end
  endgenerate

  // channel value report
  always_ff @(posedge sys_clk) begin
    if (rst) chan_value <= '0;
    else for (int c = 0; c < CHANS; c++) chan_value[c*DW +: DW] <= sval[c];
  end

  // no privileged write below level one
  a_level_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (need_lv && level != `AIR_LEVEL_ADV) |=> cmd_err)
    else $error("privileged write accepted at low level");
  a_arg_limit: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_valid && cmd_nargs > `AIR_MAX_ARGS) |=> cmd_err)
    else $error("over long command accepted");
  // find a row of axis 0 with one unit coefficient and zeros elsewhere
  logic [3:0] nz0;
  logic       one0;
  logic [2:0] sole0_idx;
  always_comb begin
    nz0       = 4'h0;
    one0      = 1'b0;
    sole0_idx = 3'h0;
    for (int c = 0; c < CHANS; c++) begin
      if (coef[0][c] != '0) nz0 = nz0 + 4'h1;
      if (coef[0][c] == DW'(1)) begin
        one0      = 1'b1;
        sole0_idx = 3'(c);
      end
    end
  end
  wire sole0 = nz0 == 4'h1 && one0;
  // single unit coefficient reports channel value
  a_pos_equal: assert property (@(posedge sys_clk) disable iff (rst)
    sole0 |=> pos_fb[DW-1:0] == $past(sval[sole0_idx]))
    else $error("position differs from sole channel");
endmodule

/* verilog/air_store.sv */
`include "air_defines.svh"
// volatile and nonvolatile parameter copies for the routing
module air_store import air_pkg::*; #(
  parameter int AXES = 2,
  parameter int CHANS = 6,
  parameter int DW = 32
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  air_cmd_if.slave                  cmd,
  input  wire logic                 stop_req,
  input  wire logic [$clog2(AXES)-1:0] stop_axis,
  output logic [2:0]                src_sel   [AXES],
  output logic [2:0]                force_sel [AXES],
  output logic signed [DW-1:0]      tgt_ofs   [AXES],
  output logic signed [DW-1:0]      coef      [AXES][CHANS],
  output logic signed [DW-1:0]      rd_vol,
  output logic signed [DW-1:0]      rd_nv,
  output logic                      load_done
);
  localparam int NP = CHANS + 3;
  // slot map: 0..CHANS-1 matrix, then source, force, offset
  function automatic int slot_of(input logic [31:0] pid);
    if (pid >= `AIR_PID_MATRIX_BASE && pid - `AIR_PID_MATRIX_BASE < CHANS)
      return int'(pid - `AIR_PID_MATRIX_BASE);
    if (pid == `AIR_PID_SRC_SEL) return CHANS;
    if (pid == `AIR_PID_FORCE_SEL) return CHANS + 1;
    if (pid == `AIR_PID_TGT_OFS) return CHANS + 2;
    return -1;
  endfunction

  // nonvolatile memory survives the reset; power-up contents are zero
  logic signed [DW-1:0] nv  [AXES][NP] = '{default: '0};
  logic signed [DW-1:0] vol [AXES][NP];
  air_state_t st_r;
  // slot index, negative when the id is not a routing parameter
  wire logic signed [31:0] sl = slot_of(cmd.pid);

  // load stored routing after reset; copies and save
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r   <= AIR_ST_LOAD;
      rd_vol <= '0;
      rd_nv  <= '0;
    end else begin
      if (st_r == AIR_ST_LOAD) vol <= nv;
      st_r <= AIR_ST_RUN;
      rd_vol <= (sl >= 0) ? vol[cmd.axis][sl] : '0;
      rd_nv  <= (sl >= 0) ? nv[cmd.axis][sl] : '0;
      if (st_r == AIR_ST_RUN) begin
        if (cmd.wr_vol && sl >= 0) vol[cmd.axis][sl] <= cmd.value;
        // stop wins over a same cycle selector write
        if (stop_req) vol[stop_axis][CHANS] <= '0;
      end
      if (cmd.wr_nv && sl >= 0) nv[cmd.axis][sl] <= cmd.value;
      if (cmd.save) nv <= vol;
    end
  end

  // outputs from the volatile copy
  assign load_done = st_r == AIR_ST_RUN;
  genvar a, c;
  generate
    for (a = 0; a < AXES; a++) begin : g_o
      assign src_sel[a]   = vol[a][CHANS][2:0];
      assign force_sel[a] = vol[a][CHANS+1][2:0];
      assign tgt_ofs[a]   = vol[a][CHANS+2];
      for (c = 0; c < CHANS; c++) begin : g_c
        assign coef[a][c] = vol[a][c];
      end
    end
  endgenerate

  a_save_copy: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd.save && !cmd.wr_nv && load_done) |=> nv[0][CHANS+2] == $past(vol[0][CHANS+2]))
    else $error("save did not copy offset");
  // volatile taken from storage at start
  a_power_load: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == AIR_ST_LOAD) |=> vol[0][CHANS] == $past(nv[0][CHANS]))
    else $error("stored selector not applied");
endmodule

/* verification/air_src_model.sv */
// analog signal source on the input channels: holds one code per channel
module air_src_model #(
  parameter int CHANS = 6
) (
  // clock and update strobe
  input  wire logic                       sys_clk,
  input  wire logic                       load,
  // requested levels
  input  wire logic signed [15:0]         code [CHANS],
  // wire to the converter
  output logic signed [CHANS*16-1:0]      chan_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  initial chan_raw = '0;
  // a source holds its level between updates, like a real signal generator
  // clamp to +/-10 V
  always @(posedge sys_clk) begin
    if (load) begin
      for (int c = 0; c < CHANS; c++) begin
        chan_raw[c*16 +: 16] <= (code[c] < -16'sh7fff) ? -16'sh7fff : code[c];
      end
    end
  end
endmodule

/* verification/air_routing_bench.sv */
`include "air_defines.svh"
module air_routing_bench import air_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AXES = 2;
  localparam int CHANS = 6;
  localparam int DW = 32;
  logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, load = 1'b0;
  air_op_t cmd_op = AIR_OP_NONE;
  logic [3:0] cmd_nargs = 4'h0;
  logic [0:0] cmd_axis = 1'h0;
  logic [31:0] cmd_pid = 32'h0;
  logic signed [DW-1:0] cmd_value = '0, rd_vol, rd_nv;
  logic [1:0] cmd_level_req = 2'h0, level, servo_on = 2'h3, src_active;
  logic signed [CHANS*16-1:0] chan_raw;
  logic signed [CHANS*DW-1:0] chan_offset = '0, chan_gain = '0, chan_value;
  logic signed [AXES*DW-1:0] motion_target = '0, pos_fb, force_fb, axis_target, axis_control;
  logic cmd_ack, cmd_err;
  logic signed [15:0] code [CHANS];
  int ofs [CHANS], gn [CHANS], rawv [CHANS], coef [AXES][CHANS], tgo [AXES];
  int errors = 0, tests_run = 0;
  int unsigned lfsr = 72312;
  always #2.5 sys_clk = ~sys_clk;
  air_src_model #(.CHANS(CHANS)) src (.sys_clk(sys_clk), .load(load), .code(code),
    .chan_raw(chan_raw));
  air_routing #(.AXES(AXES), .CHANS(CHANS), .DW(DW)) dut (.sys_clk(sys_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_nargs(cmd_nargs), .cmd_axis(cmd_axis),
    .cmd_pid(cmd_pid), .cmd_value(cmd_value), .cmd_level_req(cmd_level_req),
    .chan_raw(chan_raw), .chan_offset(chan_offset), .chan_gain(chan_gain),
    .servo_on(servo_on), .motion_target(motion_target), .cmd_ack(cmd_ack),
    .cmd_err(cmd_err), .level(level), .pos_fb(pos_fb), .force_fb(force_fb),
    .axis_target(axis_target), .axis_control(axis_control), .src_active(src_active),
    .chan_value(chan_value), .rd_vol(rd_vol), .rd_nv(rd_nv));
  // galois step, fixed seed so a failing run repeats exactly
  function automatic int rnd();
    lfsr = lfsr[0] ? ((lfsr >> 1) ^ 32'h80200003) : (lfsr >> 1);
    return int'(lfsr);
  endfunction
  // reference scaling: truncating divide, as the converter chain does
  function automatic int exp_chan(int c);
    return ofs[c] + gn[c] * ((rawv[c] * 100) / 32767);
  endfunction
  function automatic int exp_pos(int a);
    int s;
    s = 0;
    for (int c = 0; c < CHANS; c++) s += coef[a][c] * exp_chan(c);
    return s;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // new source levels, offsets and motion targets from the lfsr; gains fixed per channel
  task automatic new_inputs();
    for (int c = 0; c < CHANS; c++) begin
      rawv[c] = rnd() % 32767;
      code[c] = rawv[c][15:0];
      ofs[c] = rnd() % 50;
      gn[c] = 1 + c % 3;
      chan_offset[c*DW +: DW] = ofs[c];
      chan_gain[c*DW +: DW] = gn[c];
    end
    motion_target = {rnd(), rnd()};
    load = 1'b1;
    @(negedge sys_clk);
    load = 1'b0;
  endtask
  // one command, strobe held for exactly one taking edge
  task automatic cmd(input air_op_t op, input int ax, input int pid, input int val,
                     input int na, input logic e);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_axis = 1'(ax);
    cmd_pid = 32'(pid);
    cmd_value = val;
    cmd_nargs = 4'(na);
    cmd_level_req = 2'(val);
    @(negedge sys_clk);
    // ack and err stand for the one cycle after the taking edge
    chk({31'h0, cmd_ack}, 32'h1);
    chk({31'h0, cmd_err}, {31'h0, e});
    cmd_valid = 1'b0;
    @(negedge sys_clk);
  endtask
  // pipeline depth taken from the hand-over walk, with margin
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("CHECK FAILED t=%0t run did not finish", $time);
    report_and_stop();
  end
  initial begin
    new_inputs();
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    // offset command needs no level
    tgo[0] = rnd() % 40;
    tgo[1] = rnd() % 40;
    for (int a = 0; a < AXES; a++) cmd(AIR_OP_OFS, a, 0, tgo[a], 2, 1'b0);
    cmd(AIR_OP_LEVEL, 0, 0, 1, 2, 1'b0);
    chk({30'h0, level}, 32'h1);
    // host writes one sole coefficient per axis, the rest zero
    for (int a = 0; a < AXES; a++) begin
      for (int c = 0; c < CHANS; c++) begin
        coef[a][c] = (a == 0 && c == 4) ? 1 : ((a == 1 && c == 1) ? 2 : 0);
        cmd(AIR_OP_SET, a, `AIR_PID_MATRIX_BASE + c, coef[a][c], 3, 1'b0);
      end
      cmd(AIR_OP_SET, a, `AIR_PID_FORCE_SEL, a * 6, 3, 1'b0);
      cmd(AIR_OP_SET, a, `AIR_PID_SRC_SEL, 0, 3, 1'b0);
    end
    new_inputs();
    settle();
    for (int c = 0; c < CHANS; c++) chk(chan_value[c*DW +: DW], exp_chan(c));
    chk(pos_fb[0 +: DW], exp_pos(0));
    chk(pos_fb[DW +: DW], exp_pos(1));
    chk(pos_fb[0 +: DW], chan_value[4*DW +: DW]);
    chk(force_fb[DW +: DW], exp_chan(5));
    // servo state is only changed while no source is connected
    for (int s = 0; s < 2; s++) begin
      servo_on[0] = 1'(s);
      cmd(AIR_OP_SET, 0, `AIR_PID_SRC_SEL, 5, 3, 1'b0);
      new_inputs();
      settle();
      chk({31'h0, src_active[0]}, 32'h1);
      if (s == 1) chk(axis_target[0 +: DW], exp_chan(4) + tgo[0]);
      else chk(axis_control[0 +: DW], exp_chan(4) + tgo[0]);
      if (s == 1) cmd(AIR_OP_STOP, 0, 0, 0, 1, 1'b0);
      else cmd(AIR_OP_SET, 0, `AIR_PID_SRC_SEL, 0, 3, 1'b0);
      settle();
      chk({31'h0, src_active[0]}, 32'h0);
    end
    chk(axis_target[0 +: DW], motion_target[0 +: DW]);
    cmd(AIR_OP_SET, 0, `AIR_PID_SRC_SEL, 5, 13, 1'b1);
    settle();
    chk({31'h0, src_active[0]}, 32'h0);
    cmd(AIR_OP_SET, 0, `AIR_PID_SRC_SEL, 5, 12, 1'b0);
    cmd(AIR_OP_NVW, 0, `AIR_PID_TGT_OFS, 77, 3, 1'b0);
    cmd_pid = `AIR_PID_TGT_OFS;
    repeat (2) @(negedge sys_clk);
    chk(rd_nv, 32'd77);
    chk(rd_vol, tgo[0]);
    cmd(AIR_OP_SAVE, 0, `AIR_PID_TGT_OFS, 0, 1, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk(rd_nv, tgo[0]);
    // second reset: stored routing must come back with no host action
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    settle();
    chk({30'h0, level}, 32'h0);
    chk({31'h0, src_active[0]}, 32'h1);
    chk(axis_target[0 +: DW], exp_chan(4) + tgo[0]);
    cmd(AIR_OP_SET, 0, `AIR_PID_SRC_SEL, 0, 3, 1'b1);
    settle();
    chk({31'h0, src_active[0]}, 32'h1);
    report_and_stop();
  end
endmodule
